// File: wim_defines.svh
// Offsets, field codes, reset values and timing counts of the wake input monitor
`ifndef WIM_DEFINES_SVH
`define WIM_DEFINES_SVH

`define WIM_CLK_PERIOD_NS  4
`define WIM_FILT_SHORT_NS  16000
`define WIM_FILT_LONG_NS   64000
`define WIM_FILT_SHORT_CYC ((`WIM_FILT_SHORT_NS + `WIM_CLK_PERIOD_NS - 1) / `WIM_CLK_PERIOD_NS)
`define WIM_FILT_LONG_CYC  ((`WIM_FILT_LONG_NS + `WIM_CLK_PERIOD_NS - 1) / `WIM_CLK_PERIOD_NS)

`define WIM_OFS_MODE       8'h00
`define WIM_OFS_ENABLE     8'h04
`define WIM_OFS_BIAS       8'h08
`define WIM_OFS_FILTER     8'h0c
`define WIM_OFS_EVENT      8'h10
`define WIM_OFS_ALT_EVENT  8'h14
`define WIM_OFS_LEVEL      8'h18

`define WIM_MODE_ACTIVE    2'h0
`define WIM_MODE_STOP      2'h1
`define WIM_MODE_SLEEP     2'h2
`define WIM_MODE_FAILSAFE  2'h3

`define WIM_BIAS_NONE      2'h0
`define WIM_BIAS_DOWN      2'h1
`define WIM_BIAS_UP        2'h2
`define WIM_BIAS_AUTO      2'h3

`define WIM_FLT_STAT16     2'h0
`define WIM_FLT_STAT64     2'h1
`define WIM_FLT_CYC_A      2'h2
`define WIM_FLT_CYC_B      2'h3

`define WIM_RST_MODE       2'h0
`define WIM_RST_ENABLE     5'h00
`define WIM_RST_BIAS       6'h00
`define WIM_RST_FILTER     6'h00

`endif

// File: wim_pkg.sv
// Types shared by the wake input monitor
`default_nettype none

package wim_pkg;

    typedef logic [1:0] wim_sel_type;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } wim_addr_ph_type;

endpackage

`default_nettype wire

// File: wim_wake_input_monitor.sv
// Wake input monitor: pin filters, wake and interrupt signalling, AHB-Lite registers
`include "wim_defines.svh"
`default_nettype none

// Function
// - Both rising and falling filtered transitions on a wake pin count as events.
// - Events interrupt in active or stop mode, wake the device in sleep or failsafe.
// - Static sensing watches pins always; cyclic sensing only inside the timer window.
// - An event is accepted only if the level holds for the whole filter time.
// - Each wake pin has its own enable; a disabled pin never acts as wake source.
// - Per-pin flags in the event status register record the wake source, always readable.
// - In active and stop mode the level register shows every wake pin level.
// - Under cyclic sensing the level register shows levels sampled in the window.
// - Fail-output pins used as wake inputs use a fixed 16 us filter, own status register.
// - Bias code 00 gives no current, 01 pull-down, 10 pull-up; 00 after reset.
// - Bias code 11 pulls up while the pin is high and down while low.
// - Filter code 00 is static 16 us, code 01 static 64 us.
// - Filter codes 10 and 11 are cyclic on timer A or B, with 16 us filter.
module wim_wake_input_monitor
    import wim_pkg::*;
#(
    parameter int unsigned FILT_SHORT_CYC = `WIM_FILT_SHORT_CYC,
    parameter int unsigned FILT_LONG_CYC  = `WIM_FILT_LONG_CYC,
    parameter int unsigned CNT_W          = 16
)
(
    input  wire logic        ref_clk_in,
    input  wire logic        resetn_in,
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output var  logic [31:0] hrdata_out,
    output var  logic        hreadyout_out,
    output var  logic        hresp_out,
    input  wire logic [2:0]  wake_pin_in,
    input  wire logic [1:0]  fail_output_pins_in,
    input  wire logic        timer_a_window_in,
    input  wire logic        timer_b_window_in,
    output var  logic [2:0]  pull_up_out,
    output var  logic [2:0]  pull_down_out,
    output var  logic        irq_out,
    output var  logic        wake_out
);

    localparam int LANES = 5;

    logic [1:0]       mode;
    logic [4:0]       wake_enable_ctrl;
    logic [5:0]       bias_current_ctrl;
    logic [5:0]       detect_filter_ctrl;
    logic [2:0]       wake_event_status;
    logic [1:0]       alt_event_status;
    logic [2:0]       pin_level_status;
    wim_addr_ph_type  addr_ph;
    logic [LANES-1:0] pin_raw;
    logic [LANES-1:0] sync1;
    logic [LANES-1:0] sync2;
    logic [LANES-1:0] sync3;
    logic [LANES-1:0] filt_lvl;
    logic [LANES-1:0] acc;
    logic [LANES-1:0] open_win;
    logic [CNT_W-1:0] cnt [LANES];
    logic [2:0]       new_wk;
    logic [1:0]       new_fo;
    logic             awake;
    logic             addr_take;
    logic             wr;
    logic [2:0]       evt_clr;
    logic [1:0]       alt_clr;

    // ---------------------------------------------------------------
    // Input synchronisers
    // ---------------------------------------------------------------
    assign pin_raw = {fail_output_pins_in, wake_pin_in};

    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            sync1 <= 5'h00;
            sync2 <= 5'h00;
            sync3 <= 5'h00;
        end
        else
        begin
            sync1 <= pin_raw;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // ---------------------------------------------------------------
    // Glitch filters, one per lane; lanes 3 and 4 are the fail outputs
    // ---------------------------------------------------------------
    for (genvar i = 0; i < LANES; i++)
    begin : g_lane
        wim_sel_type      sel;
        logic [CNT_W-1:0] lim;

        if (i < 3)
        begin : g_wk
            assign sel = detect_filter_ctrl[2*i +: 2];
        end
        else
        begin : g_fo
            assign sel = `WIM_FLT_STAT16;
        end

        always_comb
        begin
            case (sel)
                `WIM_FLT_STAT64: lim = CNT_W'(FILT_LONG_CYC);
                default:         lim = CNT_W'(FILT_SHORT_CYC);
            endcase
            case (sel)
                `WIM_FLT_CYC_A: open_win[i] = timer_a_window_in;
                `WIM_FLT_CYC_B: open_win[i] = timer_b_window_in;
                default:        open_win[i] = 1'b1;
            endcase
        end

        // Accept once the new level has stood for the full filter time
        assign acc[i] = open_win[i] && (sync2[i] != filt_lvl[i])
                        && (sync2[i] == sync3[i]) && (cnt[i] == lim - 1'b1);

        always_ff @(posedge ref_clk_in or negedge resetn_in)
        begin
            if (!resetn_in)
            begin
                cnt[i] <= '0;
            end
            else if (!open_win[i] || sync2[i] == filt_lvl[i] || sync2[i] != sync3[i] || acc[i])
            begin
                cnt[i] <= '0;
            end
            else
            begin
                cnt[i] <= cnt[i] + 1'b1;
            end
        end

        always_ff @(posedge ref_clk_in or negedge resetn_in)
        begin
            if (!resetn_in)
            begin
                filt_lvl[i] <= 1'b0;
            end
            else if (acc[i])
            begin
                filt_lvl[i] <= sync2[i];
            end
        end
    end

    // ---------------------------------------------------------------
    // Event routing and status
    // ---------------------------------------------------------------
    assign new_wk = acc[2:0] & wake_enable_ctrl[2:0];
    assign new_fo = acc[4:3] & wake_enable_ctrl[4:3];
    assign awake  = (mode == `WIM_MODE_ACTIVE) || (mode == `WIM_MODE_STOP);

    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            irq_out  <= 1'b0;
            wake_out <= 1'b0;
        end
        else
        begin
            irq_out  <= awake && (|{new_wk, new_fo});
            wake_out <= !awake && (|{new_wk, new_fo});
        end
    end

    // Write-one-to-clear; a new event in the clearing cycle wins
    assign evt_clr = (wr && addr_ph.addr == `WIM_OFS_EVENT) ? hwdata_in[2:0] : 3'h0;
    assign alt_clr = (wr && addr_ph.addr == `WIM_OFS_ALT_EVENT) ? hwdata_in[1:0] : 2'h0;

    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            wake_event_status <= 3'h0;
            alt_event_status  <= 2'h0;
        end
        else
        begin
            wake_event_status <= (wake_event_status & ~evt_clr) | new_wk;
            alt_event_status  <= (alt_event_status & ~alt_clr) | new_fo;
        end
    end

    // Filtered level only moves inside the window when cyclic
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            pin_level_status <= 3'h0;
        end
        else if (awake)
        begin
            pin_level_status <= filt_lvl[2:0];
        end
    end

    // ---------------------------------------------------------------
    // Bias current sources
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            pull_up_out   <= 3'h0;
            pull_down_out <= 3'h0;
        end
        else
        begin
            for (int k = 0; k < 3; k++)
            begin
                pull_up_out[k]   <= (bias_current_ctrl[2*k +: 2] == `WIM_BIAS_UP)
                                    || (bias_current_ctrl[2*k +: 2] == `WIM_BIAS_AUTO && filt_lvl[k]);
                pull_down_out[k] <= (bias_current_ctrl[2*k +: 2] == `WIM_BIAS_DOWN)
                                    || (bias_current_ctrl[2*k +: 2] == `WIM_BIAS_AUTO && !filt_lvl[k]);
            end
        end
    end

    // ---------------------------------------------------------------
    // AHB-Lite slave
    // ---------------------------------------------------------------
    assign addr_take = hsel_in && hready_in && htrans_in[1];
    assign wr        = addr_ph.valid && addr_ph.write;

    function automatic logic [31:0] rd_mux(input logic [7:0] a);
        logic [31:0] d;
        d = 32'h0;
        case (a)
            `WIM_OFS_MODE:      d[1:0] = mode;
            `WIM_OFS_ENABLE:    d[4:0] = wake_enable_ctrl;
            `WIM_OFS_BIAS:      d[5:0] = bias_current_ctrl;
            `WIM_OFS_FILTER:    d[5:0] = detect_filter_ctrl;
            `WIM_OFS_EVENT:     d[2:0] = wake_event_status;
            `WIM_OFS_ALT_EVENT: d[1:0] = alt_event_status;
            `WIM_OFS_LEVEL:     d[2:0] = pin_level_status;
            default:            d = 32'h0;
        endcase
        return d;
    endfunction

    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            addr_ph       <= '0;
            hrdata_out    <= 32'h0;
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
        end
        else
        begin
            addr_ph.valid <= addr_take;
            addr_ph.write <= hwrite_in;
            addr_ph.addr  <= haddr_in[7:0];
            hrdata_out    <= (addr_take && !hwrite_in) ? rd_mux(haddr_in[7:0]) : 32'h0;
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            mode               <= `WIM_RST_MODE;
            wake_enable_ctrl   <= `WIM_RST_ENABLE;
            bias_current_ctrl  <= `WIM_RST_BIAS;
            detect_filter_ctrl <= `WIM_RST_FILTER;
        end
        else if (wr)
        begin
            case (addr_ph.addr)
                `WIM_OFS_MODE:   mode               <= hwdata_in[1:0];
                `WIM_OFS_ENABLE: wake_enable_ctrl   <= hwdata_in[4:0];
                `WIM_OFS_BIAS:   bias_current_ctrl  <= hwdata_in[5:0];
                `WIM_OFS_FILTER: detect_filter_ctrl <= hwdata_in[5:0];
                default:         mode               <= mode;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!resetn_in);

    chk_edge_either: assert property (acc[0] |=> filt_lvl[0] == $past(sync2[0]) && $changed(filt_lvl[0]))
        else $error("accepted edge did not move filtered level");

    chk_irq_awake: assert property ((|new_wk) && awake |=> irq_out && !wake_out)
        else $error("event in awake mode did not interrupt");

    chk_wake_asleep: assert property ((|new_wk) && !awake |=> wake_out && !irq_out)
        else $error("event in low power mode did not wake");

    chk_window_gate: assert property (detect_filter_ctrl[1:0] == `WIM_FLT_CYC_A && !timer_a_window_in |-> !acc[0])
        else $error("cyclic lane accepted outside window");

    chk_filter_hold: assert property (acc[0] |-> $stable(sync2[0]) && $past(sync2[0], 2) == sync2[0])
        else $error("event accepted on unstable level");

    chk_disabled_quiet: assert property (acc[1] && !wake_enable_ctrl[1] |=> !$rose(wake_event_status[1]))
        else $error("disabled pins produced a signal");

    chk_source_flag: assert property (acc[2] && wake_enable_ctrl[2] |=> wake_event_status[2])
        else $error("wake source flag not set");

    chk_level_track: assert property (awake |=> pin_level_status == $past(filt_lvl[2:0]))
        else $error("level status does not follow pin");

    chk_alt_flag: assert property (acc[3] && wake_enable_ctrl[3] |=> alt_event_status[0] && !$rose(wake_event_status[0]))
        else $error("fail output event misreported");

    chk_bias_auto: assert property (bias_current_ctrl[5:4] == `WIM_BIAS_AUTO
        |=> pull_up_out[2] == $past(filt_lvl[2]) && pull_down_out[2] != pull_up_out[2])
        else $error("auto bias not following level");

endmodule

`default_nettype wire

// File: wim_wake_input_monitor_tail_note_unused.sv
// Intentionally empty compilation unit
`default_nettype none
`default_nettype wire

// File: wim_pin_model.sv
// Behavioural model of the external switches on the wake pins
`default_nettype none

module wim_pin_model
    import wim_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic [2:0] level_in,
    input  wire logic [2:0] drive_in,
    input  wire logic [2:0] pull_up_in,
    input  wire logic [2:0] pull_down_in,
    output var  logic [2:0] pin_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [2:0] drift = 3'h0;

    // Open pin with no current source wanders every cycle
    always @(posedge clk_in)
    begin
        drift <= ~drift;
    end

    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            if (drive_in[i])
                pin_out[i] = level_in[i];
            else if (pull_up_in[i])
                pin_out[i] = 1'b1;
            else if (pull_down_in[i])
                pin_out[i] = 1'b0;
            else
                pin_out[i] = drift[i];
        end
    end
endmodule

`default_nettype wire

// File: wim_wake_input_monitor_tb.sv
// Self-checking testbench of the wake input monitor
`default_nettype none

module wim_wake_input_monitor_tb;
    import wim_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {string n; logic [31:0] v;} wim_exp_type;

    logic        clk = 1'b0;
    logic        rstn, hsel, hwrite, wa, wb, hro, hresp, irq, wk, rdp;
    logic [1:0]  htrans, fo;
    logic [2:0]  hsize, lvl, drv, pu, pd, pins;
    logic [31:0] haddr, hwdata, hrd;
    logic [31:0] seed = 32'h56;
    int          miscompares = 0;
    int          num_checks = 0;
    wim_exp_type rq[$];
    wim_exp_type e;
    logic [31:0] eq[$];

    always #2 clk = ~clk;

    wim_wake_input_monitor #(.FILT_SHORT_CYC(8), .FILT_LONG_CYC(20), .CNT_W(16)) dut (
        .ref_clk_in(clk), .resetn_in(rstn), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
        .hready_in(hro), .hrdata_out(hrd), .hreadyout_out(hro), .hresp_out(hresp),
        .wake_pin_in(pins), .fail_output_pins_in(fo), .timer_a_window_in(wa),
        .timer_b_window_in(wb), .pull_up_out(pu), .pull_down_out(pd), .irq_out(irq), .wake_out(wk));

    wim_pin_model model (.clk_in(clk), .level_in(lvl), .drive_in(drv), .pull_up_in(pu),
        .pull_down_in(pd), .pin_out(pins));

    // --------
    // Helpers
    // --------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic tally_and_finish();
        if (miscompares == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input string n, input logic [31:0] s, input logic [31:0] x);
        num_checks++;
        if (s !== x)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, x, s);
        end
    endtask

    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hro !== 1'b1 && ++n < 20);
        htrans <= 2'h0;
        hwdata <= d;
        rdp <= !w;
        do @(posedge clk); while (hro !== 1'b1 && ++n < 20);
        rdp <= 1'b0;
        if (n >= 20)
        begin
            miscompares++;
            tally_and_finish();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask

    task automatic rd(input string n, input logic [7:0] a, input logic [31:0] x);
        rq.push_back('{n, x});
        ahb(1'b0, a, 32'h0);
    endtask

    // Change one pin, note the event it should give, wait past the long filter
    task automatic setp(input int i, input logic v, input logic [31:0] ev);
        if (ev != 0)
            eq.push_back(ev);
        @(posedge clk);
        if (i < 3)
            lvl[i] <= v;
        else
            fo[i - 3] <= v;
        repeat (60) @(posedge clk);
    endtask

    task automatic glitch(input int i, input int len);
        @(posedge clk);
        lvl[i] <= ~lvl[i];
        repeat (len) @(posedge clk);
        lvl[i] <= ~lvl[i];
        repeat (60) @(posedge clk);
    endtask

    task automatic window(input logic b);
        wa <= !b;
        wb <= b;
        repeat (60) @(posedge clk);
        wa <= 1'b0;
        wb <= 1'b0;
    endtask

    // --------
    // Output watcher
    // --------
    always @(posedge clk)
    begin
        if (rdp && hro)
        begin
            e = rq.pop_front();
            check(e.n, hrd, e.v);
            check("hresp", {31'h0, hresp}, 32'h0);
        end
        if (rstn && (irq || wk))
            check("event", {30'h0, wk, irq}, eq.size() ? eq.pop_front() : 32'h0);
    end

    // --------
    // Main sequence
    // --------
    initial
    begin
        {hsel, hwrite, wa, wb, rdp, htrans, fo, lvl, haddr, hwdata} = '0;
        hsize = 3'h2;
        drv = 3'h7;
        rstn = 1'b0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        rd("mode", 8'h00, 0);
        rd("enable", 8'h04, 0);
        rd("bias", 8'h08, 0);
        rd("filter", 8'h0c, 0);
        rd("unmapped", 8'h1c, 0);
        wr(8'h1c, rnd());
        wr(8'h18, rnd());
        rd("level ro", 8'h18, 0);
        check("pull_up", pu, 0);
        check("pull_down", pd, 0);
        wr(8'h04, 32'h1d);
        wr(8'h08, 32'h39);
        wr(8'h0c, 32'h4);
        repeat (3) @(posedge clk);
        check("pull_up", pu, 3'b010);
        check("pull_down", pd, 3'b101);
        setp(0, 1'b1, 1);
        rd("event", 8'h10, 1);
        rd("level", 8'h18, 3'b001);
        wr(8'h10, 1);
        setp(0, 1'b0, 1);
        repeat (3) glitch(0, 1 + rnd() % 6);
        wr(8'h04, 32'h1f);
        glitch(1, 14);
        wr(8'h04, 32'h1d);
        setp(1, 1'b1, 0);
        rd("level", 8'h18, 3'b010);
        rd("event", 8'h10, 1);
        wr(8'h10, 7);
        wr(8'h00, 2);
        setp(2, 1'b1, 2);
        check("pull_up", pu, 3'b110);
        drv[2] <= 1'b0;
        repeat (60) @(posedge clk);
        drv[2] <= 1'b1;
        wr(8'h00, 3);
        setp(2, 1'b0, 2);
        wr(8'h00, 1);
        setp(0, 1'b1, 1);
        wr(8'h10, 7);
        setp(3, 1'b1, 1);
        setp(4, 1'b1, 1);
        rd("alt event", 8'h14, 3);
        rd("event", 8'h10, 0);
        wr(8'h0c, 32'h6);
        setp(0, 1'b0, 0);
        rd("level", 8'h18, 3'b011);
        eq.push_back(1);
        window(1'b0);
        rd("level", 8'h18, 3'b010);
        wr(8'h0c, 32'h7);
        wa <= 1'b1;
        setp(0, 1'b1, 0);
        wa <= 1'b0;
        eq.push_back(1);
        window(1'b1);
        rd("level", 8'h18, 3'b011);
        repeat (10) @(posedge clk);
        check("pending", eq.size() + rq.size(), 0);
        tally_and_finish();
    end
endmodule

`default_nettype wire
